// ===== dv/e1_far_side.sv
/*
  far side of the mapper: e1 line and remote modem as one slot source.
  assumes the mapper counts strobes from slot 0 after reset.
*/
`timescale 1ns/10ps
module e1_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pacing
  input wire logic go,
  input wire logic gap,
  input wire logic [4:0] last,
  // slot stream
  output logic strobe,
  output logic [7:0] line_rx,
  output logic [7:0] link_rx,
  output logic [4:0] slot
);
  // ==========
  // slot source
  logic [4:0] cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 5'h00;
      strobe <= 1'b0;
      slot <= 5'h00;
      line_rx <= 8'h00;
      link_rx <= 8'h00;
    end else if (go && !(gap && strobe)) begin
      strobe <= 1'b1;
      slot <= cnt;
      line_rx <= {3'h4, cnt};
      link_rx <= {3'h2, cnt};
      cnt <= (cnt >= last) ? 5'h00 : cnt + 5'h01;
    end else begin
      // scramble between strobes so a stale byte never passes for data
      strobe <= 1'b0;
      line_rx <= ~line_rx;
      link_rx <= ~link_rx;
    end
  end
endmodule

// ===== dv/e1_t1_timeslot_mapper_bench.sv
/*
  self-checking bench of the e1/t1 timeslot mapper.
  assumes the far side model paces slots; the config is mirrored here.
*/
`timescale 1ns/10ps
module e1_t1_timeslot_mapper_bench
  import e1_map_pkg::*;
;
  // ==========
  // signals
  logic clk, strobe, line_vld, link_vld, mgmt_vld, crc_on, port_ok;
  logic resetn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, sync_loss = 1'b0, go = 1'b0, gap = 1'b0;
  logic mon = 1'b0, loop = 1'b1;
  logic str_q = 1'b0, t1m = 1'b0, ser = 1'b0, fbit, mf_start;
  logic [4:0] flast = E1_LAST, fmf = E1_MF_LAST, frm = 5'h00;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, idle = RST_IDLE, rdata, line_rx, link_rx, line_tx, link_tx;
  logic [7:0] mgmt_rx, line_q, link_q, v;
  logic [15:0] e;
  logic [4:0] slot, slot_q;
  logic [1:0] mode = FM_BASIC;
  slot_t tbl [32] = '{default: SL_NC};
  int fail_count = 0;
  int checked = 0;

  e1_t1_timeslot_mapper #(
    .FAST_RESYNC_CYC(16), .LONG_RESYNC_CYC(40), .FBIT_PATTERN(24'hffffff)
  ) u_dut (
    .CLK(clk), .RESETN(resetn), .CE(1'b1), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .SLOT_STROBE(strobe),
    .LINE_RX_DATA(line_rx), .LINK_RX_DATA(link_rx), .MGMT_TX_DATA(8'h3c),
    .SYNC_LOSS(sync_loss), .TRANSMIT_SERIAL_INPUT(ser), .LINE_TX_DATA(line_tx),
    .LINE_TX_VALID(line_vld), .LINE_TX_FBIT(fbit), .LINE_TX_MF_START(mf_start),
    .LINK_TX_DATA(link_tx),
    .LINK_TX_VALID(link_vld), .MGMT_RX_DATA(mgmt_rx), .MGMT_RX_VALID(mgmt_vld),
    .CRC4_ENABLE(crc_on), .PORT_NORMAL(port_ok)
  );
  e1_far_side u_far (
    .clk(clk), .resetn(resetn), .go(go), .gap(gap), .strobe(strobe), .line_rx(line_rx),
    .link_rx(link_rx), .slot(slot), .last(flast)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========
  // access and checking
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] x, input logic [7:0] m = 8'hff);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    // sample after this edge's updates have landed
    #1;
    v = rdata;
    @(posedge clk);
    chk($sformatf("reg %h", a), v & m, x);
  endtask
  task automatic fill(input int lim);
    foreach (tbl[i]) begin
      if (i < lim) tbl[i] = SL_DATA;
      else tbl[i] = SL_NC;
    end
  endtask
  task automatic run(input int n, input logic g);
    gap <= g;
    go <= 1'b1;
    mon <= 1'b1;
    repeat (n) @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    mon <= 1'b0;
  endtask
  task automatic resync(input logic [7:0] c, input int lo, input int hi);
    wr(A_CTRL, c);
    sync_loss <= 1'b1;
    repeat (8) @(posedge clk);
    chk("lost", {7'h00, port_ok}, 8'h00);
    sync_loss <= 1'b0;
    repeat (lo) @(posedge clk);
    chk("early", {7'h00, port_ok}, 8'h00);
    repeat (hi - lo) @(posedge clk);
    chk("normal", {7'h00, port_ok}, 8'h01);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========
  // slot monitor: {line byte, link byte} expected for the last strobe
  function automatic logic [15:0] exp_slot();
    if (slot_q == 5'h00 && !t1m && mode == FM_BASIC && loop) return {line_q, idle};
    if (mode == FM_UNF || (slot_q == 5'h00 && !t1m) || tbl[slot_q] == SL_DATA ||
        (mode == FM_MFT && slot_q == TS16)) return {link_q, line_q};
    if (tbl[slot_q] == SL_MGMT) return {8'h3c, idle};
    return {idle, idle};
  endfunction
  always @(posedge clk) begin
    str_q <= strobe;
    if (strobe) begin
      slot_q <= slot;
      line_q <= line_rx;
      link_q <= link_rx;
    end
    if (mon) begin
      chk("line_vld", {7'h00, line_vld}, {7'h00, str_q});
    end
    if (mon && line_vld === 1'b1) begin
      e = exp_slot();
      chk("mf_start", {7'h00, mf_start}, {7'h00, slot_q == 5'h00 && frm == 5'h00});
      if (slot_q >= flast) begin
        frm <= (frm >= fmf) ? 5'h00 : frm + 5'h01;
      end
      chk("line_tx", line_tx, e[15:8]);
      chk("link_tx", link_tx, e[7:0]);
      chk("link_vld", {7'h00, link_vld}, 8'h01);
      if (tbl[slot_q] == SL_MGMT) begin
        chk("mgmt_rx", mgmt_rx, line_q);
        chk("mgmt_vld", {7'h00, mgmt_vld}, 8'h01);
      end else begin
        chk("mgmt_vld", {7'h00, mgmt_vld}, 8'h00);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  // ==========
  // tests
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rc(A_CTRL, RST_CTRL);
    rc(A_IDLE, RST_IDLE);
    rc(4'hf, 8'h00);
    run(70, 1'b0);
    wr(A_IDLE, 8'h00);
    idle = 8'h00;
    wr(A_BULK, BULK_FULL);
    fill(32);
    rc(A_USED, 8'h20);
    wr(A_CTRL, 8'h01);
    loop = 1'b0;
    run(40, 1'b1);
    wr(A_SIDX, 8'h05);
    wr(A_SVAL, 8'h02);
    rc(A_SVAL, 8'h01);
    rc(A_STAT, 8'h02, 8'h02);
    wr(A_CTRL, 8'h81);
    wr(A_SVAL, 8'h02);
    tbl[5] = SL_MGMT;
    rc(A_SVAL, 8'h02);
    wr(A_SIDX, 8'h09);
    wr(A_SVAL, 8'h02);
    rc(A_SVAL, 8'h01);
    run(40, 1'b0);
    wr(A_BULK, BULK_CLEAR);
    fill(0);
    rc(A_USED, 8'h00);
    wr(A_RATE, 8'h10);
    wr(A_BULK, BULK_FULL);
    fill(16);
    rc(A_USED, 8'h10);
    wr(A_RATE, 8'h21);
    rc(A_RATE, 8'h10);
    // status lags a loss clear by two sync stages, one state step, the count and its register
    resync(8'h01, 4, 5);
    resync(8'h05, 20, 21);
    resync(8'h09, 44, 45);
    wr(A_ROLE, 8'h00);
    wr(A_CTRL, 8'h00);
    rc(A_CTRL, 8'h01);
    wr(A_FIDL, 8'h33);
    rc(A_FIDL, RST_IDLE);
    wr(A_IDLE, 8'h7e);
    rc(A_IDLE, 8'h7e);
    idle = 8'h7e;
    wr(A_ROLE, 8'h03);
    wr(A_CTRL, 8'h02);
    rc(A_CTRL, 8'h01);
    run(20, 1'b0); // fifteen data slots besides slot 0 face the serial unit
    wr(A_ROLE, 8'h01);
    wr(A_FIDL, 8'h5a);
    rc(A_FIDL, 8'h5a);
    wr(A_CTRL, 8'h11);
    rc(A_CTRL, 8'h11);
    chk("crc", {7'h00, crc_on}, 8'h01);
    run(40, 1'b0);
    wr(A_BULK, BULK_CLEAR);
    fill(0);
    wr(A_CTRL, 8'h52);
    mode = FM_MFT;
    loop = 1'b1;
    rc(A_CTRL, 8'h62);
    chk("crc", {7'h00, crc_on}, 8'h00);
    wr(A_ROLE, 8'h00);
    wr(A_IDLE, 8'h11);
    rc(A_IDLE, 8'h7e);
    wr(A_ROLE, 8'h01);
    run(40, 1'b0);
    wr(A_CTRL, 8'h00);
    mode = FM_UNF;
    rc(A_CTRL, 8'h20);
    run(40, 1'b1);
    // t1 port: the far side wraps at slot 23 together with the mapper
    wr(A_ROLE, 8'h09);
    flast <= T1_LAST;
    t1m = 1'b1;
    wr(A_CTRL, 8'h03);
    mode = FM_SF;
    fmf = SF_MF_LAST;
    rc(A_CTRL, 8'h03);
    ser <= 1'b1;
    run(60, 1'b0);
    chk("fbit", {7'h00, fbit}, 8'h01);
    ser <= 1'b0;
    run(30, 1'b0);
    chk("fbit", {7'h00, fbit}, 8'h00);
    wr(A_ROLE, 8'h19);
    run(30, 1'b0);
    chk("fbit", {7'h00, fbit}, 8'h01);
    finish_test();
  end
endmodule

// ===== verilog/e1_map_pkg.sv
/*
  constants, field layout and types of the e1/t1 timeslot mapper.
  assumes one 20 mhz clock and 8-bit register words.
*/
package e1_map_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FAST_SEC = 1;
  localparam int unsigned LONG_SEC = 10;
  localparam int unsigned FAST_CYC = FAST_SEC * CLK_HZ;
  localparam int unsigned LONG_CYC = LONG_SEC * CLK_HZ;
  // ==========================================================
  // frame geometry and rates
  localparam int unsigned E1_SLOTS = 32;
  localparam logic [4:0] E1_LAST = 5'h1f;
  localparam logic [4:0] T1_LAST = 5'h17;
  localparam logic [4:0] TS16 = 5'h10;
  localparam logic [4:0] E1_MF_LAST = 5'h0f;
  localparam logic [4:0] ESF_MF_LAST = 5'h17;
  localparam logic [4:0] SF_MF_LAST = 5'h0b;
  localparam int unsigned AGG_KBPS = 2048;
  localparam int unsigned SLOT_KBPS = 64;
  localparam logic [5:0] AGG_SLOTS = 6'(AGG_KBPS / SLOT_KBPS);
  // ==========================================================
  // register map
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_IDLE = 4'h1;
  localparam logic [3:0] A_ROLE = 4'h2;
  localparam logic [3:0] A_RATE = 4'h3;
  localparam logic [3:0] A_SIDX = 4'h4;
  localparam logic [3:0] A_SVAL = 4'h5;
  localparam logic [3:0] A_BULK = 4'h6;
  localparam logic [3:0] A_STAT = 4'h7;
  localparam logic [3:0] A_USED = 4'h8;
  localparam logic [3:0] A_FCTL = 4'h9;
  localparam logic [3:0] A_FIDL = 4'ha;
  // ==========================================================
  // field positions
  localparam int unsigned C_FM = 0;
  localparam int unsigned C_SY = 2;
  localparam int unsigned C_CRC = 4;
  localparam int unsigned C_ID = 5;
  localparam int unsigned C_LOOP = 6;
  localparam int unsigned C_DTS = 7;
  localparam int unsigned R_CO = 0;
  localparam int unsigned R_FAR = 1;
  localparam int unsigned R_T1 = 3;
  localparam int unsigned R_FBI = 4;
  localparam int unsigned S_NORM = 0;
  localparam int unsigned S_REF = 1;
  localparam int unsigned S_LOS = 2;
  localparam int unsigned S_CRC = 3;
  localparam int unsigned S_ID = 4;
  // ==========================================================
  // reset values and commands
  localparam logic [7:0] RST_CTRL = 8'h41;
  localparam logic [7:0] RST_IDLE = 8'hff;
  localparam logic [7:0] RST_ROLE = 8'h01;
  localparam logic [7:0] BULK_FULL = 8'h01;
  localparam logic [7:0] BULK_CLEAR = 8'h02;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    FM_UNF = 2'h0, FM_BASIC = 2'h1, FM_MFT = 2'h2, FM_SF = 2'h3
  } fm_t;
  typedef enum logic [1:0] {
    SY_STD = 2'h0, SY_FAST = 2'h1, SY_LONG = 2'h2
  } sync_t;
  typedef enum logic [1:0] {
    FAR_E1 = 2'h0, FAR_SER = 2'h1, FAR_LAN = 2'h2
  } far_t;
  typedef enum logic [1:0] {
    SL_NC = 2'h0, SL_DATA = 2'h1, SL_MGMT = 2'h2
  } slot_t;
  typedef enum logic [2:0] {
    RS_NORM = 3'b001, RS_LOST = 3'b010, RS_WAIT = 3'b100
  } rs_t;
endpackage

// ===== verilog/e1_t1_timeslot_mapper.sv
/*
  e1/t1 port framing and timeslot mapper: slot assignment, idle fill,
  timeslot 0 loop/pass, write permissions and resync timing.
  assumes a line framer and link framer on the same clock giving one
  SLOT_STROBE per timeslot byte; SYNC_LOSS and TRANSMIT_SERIAL_INPUT
  are asynchronous pins.
*/
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
// Functional notes
// - unused slots carry the programmable idle byte
// - each slot is data, management or unconnected
// - one management slot, only with dedicated mode
// - bulk commands: all data, all unconnected; full makes data only the slots below the usable budget and last slot
// - looped slot 0 returns to the line
// - transparent slot 0 goes to the remote
// - multiframe mode: slot 0 passes, 16 connected
// - crc-4 only in basic framed mode
// - both user interfaces share 2048 kbps
// - lan rate shrinks the usable slot count
// - serial rate shrinks the usable slot count
// - identical settings forced yes in multiframe and unframed modes
// - framing modes allowed depend on far unit
// - unframed mode disables all other parameters
// - identical off: near always, far if central
// - multiframe: identical fixed, near needs central
// - t1 esf 24 frames, sf 12 frames
// - t1 framing bit from input or internal
// - resync after 1 s, 10 s or at once
// - basic framed slot 0 holds sync word
module e1_t1_timeslot_mapper
  import e1_map_pkg::*;
#(
  parameter int unsigned FAST_RESYNC_CYC = FAST_CYC,
  parameter int unsigned LONG_RESYNC_CYC = LONG_CYC,
  parameter logic [23:0] FBIT_PATTERN = 24'h5a5a5a
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // slot stream in
  input wire logic SLOT_STROBE,
  input wire logic [7:0] LINE_RX_DATA,
  input wire logic [7:0] LINK_RX_DATA,
  input wire logic [7:0] MGMT_TX_DATA,
  // pins
  input wire logic SYNC_LOSS,
  input wire logic TRANSMIT_SERIAL_INPUT,
  // slot stream out
  output logic [7:0] LINE_TX_DATA,
  output logic LINE_TX_VALID,
  output logic LINE_TX_FBIT,
  output logic LINE_TX_MF_START,
  output logic [7:0] LINK_TX_DATA,
  output logic LINK_TX_VALID,
  output logic [7:0] MGMT_RX_DATA,
  output logic MGMT_RX_VALID,
  // status
  output logic CRC4_ENABLE,
  output logic PORT_NORMAL
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] idle;
    logic [7:0] role;
    logic [5:0] rate;
    logic [4:0] idx;
    slot_t [E1_SLOTS-1:0] tab;
    logic [7:0] fctl;
    logic [7:0] fidl;
    logic refused;
    rs_t rs;
    logic [27:0] cnt;
    logic los1;
    logic los2;
    logic ser1;
    logic ser2;
    logic [4:0] slot;
    logic [4:0] mf;
    logic [7:0] line_tx;
    logic line_v;
    logic fbit;
    logic mfs;
    logic [7:0] link_tx;
    logic link_v;
    logic [7:0] mg_d;
    logic mg_v;
    logic crc;
    logic normal;
    logic [7:0] rdata;
  } st_t;

  st_t st_ff;
  st_t nxt_st;

  // ==========================================================
  // decode helpers
  function automatic logic fm_ok(logic t1, logic fe1, fm_t v);
    if (t1) begin
      fm_ok = (v != FM_MFT);
    end else if (fe1) begin
      fm_ok = (v != FM_SF);
    end else begin
      fm_ok = (v == FM_BASIC) || (v == FM_UNF);
    end
  endfunction

  function automatic slot_t eff_slot(fm_t m, logic t1, logic [4:0] s,
                                     slot_t v);
    if (!t1 && m == FM_MFT && (s == 5'h0 || s == TS16)) begin
      eff_slot = SL_DATA;
    end else begin
      eff_slot = v;
    end
  endfunction

  fm_t fm;
  sync_t sy;
  logic co, fe1, t1, mft, unf, id_eff, crc_eff;
  logic ne_fm_wr, fe_fm_wr, ne_cfg_wr, fe_cfg_wr, id_wr;
  logic [5:0] limit, data_cnt, mgmt_cnt, data_oth, mgmt_oth;
  logic [4:0] last;
  slot_t cur;
  logic ts0;

  assign fm = fm_t'(st_ff.ctrl[C_FM+:2]);
  assign sy = sync_t'(st_ff.ctrl[C_SY+:2]);
  assign co = st_ff.role[R_CO];
  assign fe1 = (far_t'(st_ff.role[R_FAR+:2]) == FAR_E1);
  assign t1 = st_ff.role[R_T1];
  assign mft = (fm == FM_MFT);
  assign unf = (fm == FM_UNF);
  assign id_eff = mft || unf || st_ff.ctrl[C_ID];
  assign crc_eff = st_ff.ctrl[C_CRC] && fm == FM_BASIC && !t1;
  assign ne_fm_wr = co || !fe1;
  assign fe_fm_wr = t1 && co;
  assign id_wr = !(mft || unf) && co && fe1;
  assign ne_cfg_wr = unf ? 1'b0 : mft ? co : id_eff ? (co || !fe1) : 1'b1;
  assign fe_cfg_wr = (unf || mft) ? 1'b0 : id_eff ? (t1 && !co) : co;
  assign limit = AGG_SLOTS - st_ff.rate;
  assign last = t1 ? T1_LAST : E1_LAST;
  assign cur = eff_slot(fm, t1, st_ff.slot, st_ff.tab[st_ff.slot]);
  assign ts0 = !t1 && !unf && st_ff.slot == 5'h0;

  always_comb begin
    data_cnt = '0;
    mgmt_cnt = '0;
    data_oth = '0;
    mgmt_oth = '0;
    for (int i = 0; i < E1_SLOTS; i++) begin
      if (st_ff.tab[i] == SL_DATA) begin
        data_cnt = data_cnt + 6'h1;
        if (5'(i) != st_ff.idx) begin
          data_oth = data_oth + 6'h1;
        end
      end
      if (st_ff.tab[i] == SL_MGMT) begin
        mgmt_cnt = mgmt_cnt + 6'h1;
        if (5'(i) != st_ff.idx) begin
          mgmt_oth = mgmt_oth + 6'h1;
        end
      end
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    fm_t wfm;
    slot_t wsl;
    logic fm_upd, bad;
    wfm = fm_t'(REG_WDATA[C_FM+:2]);
    wsl = slot_t'(REG_WDATA[1:0]);
    fm_upd = ne_fm_wr && fm_ok(t1, fe1, wfm);
    bad = 1'b0;
    nxt_st = st_ff;
    nxt_st.rdata = '0;
    nxt_st.line_v = 1'b0;
    nxt_st.link_v = 1'b0;
    nxt_st.mg_v = 1'b0;
    nxt_st.mfs = 1'b0;
    nxt_st.los1 = SYNC_LOSS;
    nxt_st.los2 = st_ff.los1;
    nxt_st.ser1 = TRANSMIT_SERIAL_INPUT;
    nxt_st.ser2 = st_ff.ser1;
    nxt_st.crc = crc_eff;
    nxt_st.normal = (st_ff.rs == RS_NORM);

    // register reads
    if (REG_RD) begin
      unique case (REG_ADDR)
        A_CTRL: nxt_st.rdata = {st_ff.ctrl[7:6], id_eff, crc_eff,
                                st_ff.ctrl[3:0]};
        A_IDLE: nxt_st.rdata = st_ff.idle;
        A_ROLE: nxt_st.rdata = st_ff.role;
        A_RATE: nxt_st.rdata = {2'h0, st_ff.rate};
        A_SIDX: nxt_st.rdata = {3'h0, st_ff.idx};
        A_SVAL: nxt_st.rdata = {6'h0, st_ff.tab[st_ff.idx]};
        A_STAT: begin
          nxt_st.rdata = {3'h0, id_eff, crc_eff, st_ff.los2,
                          st_ff.refused, st_ff.normal};
          nxt_st.refused = 1'b0;
        end
        A_USED: nxt_st.rdata = {2'h0, data_cnt};
        A_FCTL: nxt_st.rdata = st_ff.fctl;
        A_FIDL: nxt_st.rdata = st_ff.fidl;
        default: nxt_st.rdata = '0;
      endcase
    end

    // register writes; a blocked field keeps its value
    if (REG_WR) begin
      unique case (REG_ADDR)
        A_CTRL: begin
          if (fm_upd) begin
            nxt_st.ctrl[C_FM+:2] = REG_WDATA[C_FM+:2];
          end
          if (ne_fm_wr) begin
            nxt_st.ctrl[C_CRC] = REG_WDATA[C_CRC] && !t1
                                 && fm_t'(nxt_st.ctrl[C_FM+:2]) == FM_BASIC;
          end
          if (ne_cfg_wr) begin
            nxt_st.ctrl[C_SY+:2] = REG_WDATA[C_SY+:2];
            nxt_st.ctrl[C_LOOP] = REG_WDATA[C_LOOP];
          end
          if (id_wr) begin
            nxt_st.ctrl[C_ID] = REG_WDATA[C_ID];
          end
          nxt_st.ctrl[C_DTS] = REG_WDATA[C_DTS];
          bad = (REG_WDATA[C_FM+:2] != st_ff.ctrl[C_FM+:2] && !fm_upd)
                || (REG_WDATA[C_CRC] != nxt_st.ctrl[C_CRC])
                || (REG_WDATA[C_SY+:2] != st_ff.ctrl[C_SY+:2] && !ne_cfg_wr);
        end
        A_IDLE: begin
          if (ne_cfg_wr) begin
            nxt_st.idle = REG_WDATA;
          end
          bad = !ne_cfg_wr;
        end
        A_ROLE: nxt_st.role = REG_WDATA;
        A_RATE: begin
          if (REG_WDATA <= 8'(AGG_SLOTS)
              && 7'(REG_WDATA[5:0]) + 7'(data_cnt) <= 7'(AGG_SLOTS)) begin
            nxt_st.rate = REG_WDATA[5:0];
          end else begin
            bad = 1'b1;
          end
        end
        A_SIDX: nxt_st.idx = REG_WDATA[4:0];
        A_SVAL: begin
          bad = !ne_cfg_wr || REG_WDATA[7:2] != 6'h0 || wsl == 2'h3
                || (t1 && st_ff.idx > T1_LAST);
          if (wsl == SL_MGMT && (!st_ff.ctrl[C_DTS] || mgmt_oth != 6'h0)) begin
            bad = 1'b1;
          end
          if (wsl == SL_DATA && data_oth >= limit) begin
            bad = 1'b1;
          end
          if (!bad) begin
            nxt_st.tab[st_ff.idx] = wsl;
          end
        end
        A_BULK: begin
          bad = !ne_cfg_wr;
          for (int i = 0; i < E1_SLOTS; i++) begin
            if (ne_cfg_wr && REG_WDATA == BULK_CLEAR) begin
              nxt_st.tab[i] = SL_NC;
            end
            if (ne_cfg_wr && REG_WDATA == BULK_FULL) begin
              // full stops at the usable slot budget
              nxt_st.tab[i] = (6'(i) < limit && 5'(i) <= last) ? SL_DATA : SL_NC;
            end
          end
        end
        A_FCTL: begin
          if (fe_fm_wr) begin
            nxt_st.fctl[C_FM+:2] = REG_WDATA[C_FM+:2];
            nxt_st.fctl[C_CRC] = REG_WDATA[C_CRC]
                                 && fm_t'(REG_WDATA[C_FM+:2]) == FM_BASIC;
          end
          if (fe_cfg_wr) begin
            nxt_st.fctl[C_SY+:2] = REG_WDATA[C_SY+:2];
          end
          bad = !fe_fm_wr && !fe_cfg_wr;
        end
        A_FIDL: begin
          if (fe_cfg_wr) begin
            nxt_st.fidl = REG_WDATA;
          end
          bad = !fe_cfg_wr;
        end
        default: bad = 1'b0;
      endcase
    end
    if (bad) begin
      nxt_st.refused = 1'b1;
    end

    // resync after loss of frame alignment
    unique case (st_ff.rs)
      RS_NORM: begin
        if (st_ff.los2) begin
          nxt_st.rs = RS_LOST;
        end
      end
      RS_LOST: begin
        nxt_st.cnt = '0;
        if (!st_ff.los2) begin
          nxt_st.rs = (sy == SY_FAST || sy == SY_LONG) ? RS_WAIT : RS_NORM;
        end
      end
      RS_WAIT: begin
        nxt_st.cnt = st_ff.cnt + 28'h1;
        if (st_ff.los2) begin
          nxt_st.rs = RS_LOST;
        end else if ((sy == SY_FAST && st_ff.cnt == 28'(FAST_RESYNC_CYC - 1))
                  || (sy != SY_FAST && st_ff.cnt == 28'(LONG_RESYNC_CYC - 1))) begin
          nxt_st.rs = RS_NORM;
        end
      end
      default: nxt_st.rs = RS_LOST;
    endcase

    // slot stream
    if (SLOT_STROBE) begin
      nxt_st.line_v = 1'b1;
      nxt_st.link_v = 1'b1;
      if (st_ff.slot >= last) begin
        nxt_st.slot = 5'h0;
        if (st_ff.mf >= (!t1 ? E1_MF_LAST : fm == FM_SF ? SF_MF_LAST
                                                         : ESF_MF_LAST)) begin
          nxt_st.mf = 5'h0;
        end else begin
          nxt_st.mf = st_ff.mf + 5'h1;
        end
      end else begin
        nxt_st.slot = st_ff.slot + 5'h1;
      end
      nxt_st.mfs = (st_ff.slot == 5'h0 && st_ff.mf == 5'h0);
      if (t1 && st_ff.slot == 5'h0) begin
        nxt_st.fbit = st_ff.role[R_FBI] ? FBIT_PATTERN[st_ff.mf] : st_ff.ser2;
      end
      if (unf) begin
        nxt_st.line_tx = LINK_RX_DATA; // unstructured pass
        nxt_st.link_tx = LINE_RX_DATA;
      end else if (ts0 && fm == FM_BASIC && st_ff.ctrl[C_LOOP]) begin
        nxt_st.line_tx = LINE_RX_DATA;
        nxt_st.link_tx = st_ff.idle;
      end else if (ts0) begin
        nxt_st.line_tx = LINK_RX_DATA;
        nxt_st.link_tx = LINE_RX_DATA;
      end else begin
        unique case (cur)
          SL_DATA: begin
            nxt_st.line_tx = LINK_RX_DATA;
            nxt_st.link_tx = LINE_RX_DATA;
          end
          SL_MGMT: begin
            nxt_st.line_tx = MGMT_TX_DATA;
            nxt_st.link_tx = st_ff.idle;
            nxt_st.mg_d = LINE_RX_DATA;
            nxt_st.mg_v = 1'b1;
          end
          default: begin
            nxt_st.line_tx = st_ff.idle;
            nxt_st.link_tx = st_ff.idle;
          end
        endcase
      end
      // no line traffic reaches the remote while out of alignment
      if (st_ff.rs != RS_NORM) begin
        nxt_st.link_tx = st_ff.idle;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_ff <= '0;
      st_ff.ctrl <= RST_CTRL;
      st_ff.idle <= RST_IDLE;
      st_ff.role <= RST_ROLE;
      st_ff.rs <= RS_NORM;
      st_ff.fidl <= RST_IDLE;
    end else if (CE) begin
      st_ff <= nxt_st;
    end
  end

  assign REG_RDATA = st_ff.rdata;
  assign LINE_TX_DATA = st_ff.line_tx;
  assign LINE_TX_VALID = st_ff.line_v;
  assign LINE_TX_FBIT = st_ff.fbit;
  assign LINE_TX_MF_START = st_ff.mfs;
  assign LINK_TX_DATA = st_ff.link_tx;
  assign LINK_TX_VALID = st_ff.link_v;
  assign MGMT_RX_DATA = st_ff.mg_d;
  assign MGMT_RX_VALID = st_ff.mg_v;
  assign CRC4_ENABLE = st_ff.crc;
  assign PORT_NORMAL = st_ff.normal;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_idle_slot;
    CE && SLOT_STROBE && !unf && !ts0 && cur == SL_NC;
  endsequence
  property p_idle_fill;
    s_idle_slot |=> LINE_TX_DATA == $past(st_ff.idle);
  endproperty
  a_idle_fill: assert property (p_idle_fill)
    else $error("idle byte missing in unused slot");

  property p_one_mgmt;
    mgmt_cnt <= 6'h1;
  endproperty
  a_one_mgmt: assert property (p_one_mgmt)
    else $error("more than one management slot");

  sequence s_clear;
    CE && REG_WR && REG_ADDR == A_BULK && REG_WDATA == BULK_CLEAR && ne_cfg_wr;
  endsequence
  property p_clear;
    s_clear |=> data_cnt == 6'h0 && mgmt_cnt == 6'h0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left slots assigned");

  property p_loop;
    CE && SLOT_STROBE && ts0 && fm == FM_BASIC && st_ff.ctrl[C_LOOP]
      |=> LINE_TX_DATA == $past(LINE_RX_DATA) && LINK_TX_DATA == $past(st_ff.idle);
  endproperty
  a_loop: assert property (p_loop)
    else $error("slot 0 not looped");

  property p_pass;
    CE && SLOT_STROBE && ts0 && st_ff.rs == RS_NORM
      && (mft || !st_ff.ctrl[C_LOOP])
      |=> LINK_TX_DATA == $past(LINE_RX_DATA);
  endproperty
  a_pass: assert property (p_pass)
    else $error("slot 0 not passed to remote");

  property p_ts16;
    CE && SLOT_STROBE && mft && !t1 && st_ff.slot == TS16
      |=> LINK_TX_DATA == $past(LINE_RX_DATA) || !$past(st_ff.rs == RS_NORM);
  endproperty
  a_ts16: assert property (p_ts16)
    else $error("slot 16 not connected");

  property p_crc;
    CRC4_ENABLE |-> $past(fm) == FM_BASIC && !$past(t1);
  endproperty
  a_crc: assert property (p_crc)
    else $error("crc-4 on outside basic framing");

  property p_budget;
    7'(st_ff.rate) + 7'(data_cnt) <= 7'(AGG_SLOTS);
  endproperty
  a_budget: assert property (p_budget)
    else $error("aggregate rate exceeded");

  sequence s_ctrl_read;
    CE && REG_RD && REG_ADDR == A_CTRL && (mft || unf);
  endsequence
  property p_ident;
    s_ctrl_read |=> REG_RDATA[C_ID] ##1 (REG_RDATA == 8'h0 || $past(REG_RD) || !$past(CE));
  endproperty
  a_ident: assert property (p_ident)
    else $error("identical setting not forced");

  property p_resync;
    CE && st_ff.rs == RS_WAIT && nxt_st.rs == RS_NORM
      |-> st_ff.cnt == (sy == SY_FAST ? 28'(FAST_RESYNC_CYC - 1)
                                       : 28'(LONG_RESYNC_CYC - 1));
  endproperty
  a_resync: assert property (p_resync)
    else $error("resync time wrong");

endmodule
